// [design/epcr_pkg.sv]
// Constants shared by the event profiler configuration register block
package epcr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] EPCR_ADDR_FEATURE_CONFIG = 32'hc000_0105;
  localparam logic [31:0] EPCR_ADDR_CONTROL_BLOCK = 32'hc000_0106;

  // ----------------------------------------------------------------
  // Capability word and configuration field positions
  // ----------------------------------------------------------------
  localparam int EPCR_BIT_PRESENT = 0;
  localparam int EPCR_BIT_EVENT_LO = 1;
  localparam int EPCR_BIT_EVENT_HI = 6;
  localparam int EPCR_NUM_EVENTS = 6;
  localparam int EPCR_BIT_WRAPAROUND = 29;
  localparam int EPCR_BIT_TIMESTAMP = 30;
  localparam int EPCR_BIT_THRESHOLD_IRQ = 31;
  localparam int EPCR_CORE_TAG_LO = 32;
  localparam int EPCR_CORE_TAG_HI = 39;
  localparam int EPCR_VECTOR_LO = 40;
  localparam int EPCR_VECTOR_HI = 47;
  localparam int EPCR_FEATURE_ID_BIT = 15;
  localparam int EPCR_STATE_MASK_BIT = 62;

  // Configuration bits that can ever be written: 47:32 plus supported features
  localparam logic [63:0] EPCR_FIELD_MASK = 64'h0000_ffff_0000_0000;
  localparam logic [31:0] EPCR_CAP_DEFINED = 32'he000_007f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [63:0] EPCR_CONFIG_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] EPCR_ADDR_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] EPCR_ZERO64 = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // Access response
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EPCR_RESP_OK = 2'b00,
    EPCR_RESP_GP_FAULT = 2'b01,
    EPCR_RESP_UNDEF_OP = 2'b10,
    EPCR_RESP_UNMAPPED = 2'b11
  } epcr_resp_e;

  // Profiler instructions
  typedef enum logic [1:0] {
    EPCR_INSTR_LOAD = 2'b00,
    EPCR_INSTR_STORE = 2'b01,
    EPCR_INSTR_RECORD = 2'b10,
    EPCR_INSTR_SAMPLED = 2'b11
  } epcr_instr_e;

endpackage

// [design/epcr_config_check.sv]
// Write legality check for the feature configuration register
`timescale 1ns/100ps
module epcr_config_check
  import epcr_pkg::*;
(
  input wire logic [31:0] capability,
  input wire logic [63:0] wdata,
  output logic legal,
  output logic [63:0] allowed_mask
);

  // ----------------------------------------------------------------
  // Allowed bits
  // ----------------------------------------------------------------
  // Bit 0 is never writable; feature bits follow the capability word
  always_comb begin
    allowed_mask = EPCR_FIELD_MASK;
    allowed_mask[31:1] = capability[31:1] & EPCR_CAP_DEFINED[31:1];
    if (!capability[EPCR_BIT_PRESENT]) begin
      allowed_mask[31:1] = 31'h0000_0000;
    end
    legal = ((wdata & ~allowed_mask) == EPCR_ZERO64);
  end

endmodule

// [design/epcr_event_gate.sv]
// Per-event gate from configuration bits to the counting logic
`timescale 1ns/100ps
module epcr_event_gate
  import epcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic profiling_on,
  input wire logic [EPCR_NUM_EVENTS-1:0] allow,
  input wire logic [EPCR_NUM_EVENTS-1:0] event_raw,
  output logic [EPCR_NUM_EVENTS-1:0] event_count
);

  logic [EPCR_NUM_EVENTS-1:0] next_event_count;

  // ----------------------------------------------------------------
  // Gating, one lane per event code
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < EPCR_NUM_EVENTS; gi++) begin : g_lane
      always_comb begin
        next_event_count[gi] = profiling_on & allow[gi] & event_raw[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_count <= '0;
    end else begin
      event_count <= next_event_count;
    end
  end

endmodule

// [design/epcr_top.sv]
// Event profiler capability, configuration and control block address registers
`timescale 1ns/100ps
module epcr_top
  import epcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] capability_strap,
  input wire logic feature_id_present,
  input wire logic [63:0] extended_state_mask,
  input wire logic timestamp_available,
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  output logic reg_done,
  output logic [1:0] reg_resp,
  output logic [63:0] reg_rdata,
  input wire logic instr_req,
  input wire logic [1:0] instr_op,
  input wire logic [63:0] instr_addr,
  input wire logic instr_block_valid,
  output logic instr_done,
  output logic [1:0] instr_resp,
  output logic [63:0] instr_rdata,
  input wire logic [5:0] event_raw,
  input wire logic threshold_hit,
  output logic [31:0] capability_word,
  output logic [31:0] user_query,
  output logic profiling_on,
  output logic state_discard,
  output logic wraparound_mode,
  output logic timestamp_store,
  output logic [7:0] core_tag,
  output logic [63:0] block_linear_addr,
  output logic [5:0] event_count,
  output logic irq_req,
  output logic [7:0] irq_vector
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [63:0] feature_config;
  logic [63:0] next_feature_config;
  logic [63:0] control_block_address;
  logic [63:0] next_control_block_address;
  logic [31:0] cap_clean;
  logic [31:0] next_capability_word;
  logic cfg_legal;
  logic sel_config;
  logic sel_block;
  logic next_reg_done;
  logic [1:0] next_reg_resp;
  logic [63:0] next_reg_rdata;
  logic next_instr_done;
  logic [1:0] next_instr_resp;
  logic [63:0] next_instr_rdata;
  logic next_state_discard;
  logic next_irq_req;
  logic instr_enabled;
  epcr_resp_e resp_sel;
  epcr_instr_e op_sel;
  logic [31:0] next_user_query;
  logic next_profiling_on;
  logic next_wraparound_mode;
  logic next_timestamp_store;
  logic [7:0] next_core_tag;
  logic [63:0] next_block_linear_addr;
  logic [7:0] next_irq_vector;

  // ----------------------------------------------------------------
  // Capability word
  // ----------------------------------------------------------------
  // Reserved bits forced low regardless of strap
  always_comb begin
    cap_clean = capability_strap & EPCR_CAP_DEFINED;
    cap_clean[EPCR_BIT_PRESENT] = capability_strap[EPCR_BIT_PRESENT] &
      feature_id_present;
    next_capability_word = cap_clean;
    if (!cap_clean[EPCR_BIT_PRESENT]) begin
      next_capability_word = 32'h0000_0000;
    end
  end

  epcr_config_check u_check (
    .capability(next_capability_word),
    .wdata(reg_wdata),
    .legal(cfg_legal),
    .allowed_mask()
  );

  assign instr_enabled = next_capability_word[EPCR_BIT_PRESENT] &
    extended_state_mask[EPCR_STATE_MASK_BIT];
  assign op_sel = epcr_instr_e'(instr_op);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Exact match only; any other address answers as unmapped while the feature id is present, otherwise as a fault
  always_comb begin
    sel_config = 1'b0;
    sel_block = 1'b0;
    if (reg_addr == EPCR_ADDR_FEATURE_CONFIG) begin
      sel_config = 1'b1;
    end else if (reg_addr == EPCR_ADDR_CONTROL_BLOCK) begin
      sel_block = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register and instruction next state
  // ----------------------------------------------------------------
  always_comb begin
    next_feature_config = feature_config;
    next_control_block_address = control_block_address;
    next_reg_done = 1'b0;
    next_reg_resp = reg_resp;
    next_reg_rdata = reg_rdata;
    next_instr_done = 1'b0;
    next_instr_resp = instr_resp;
    next_instr_rdata = instr_rdata;
    next_state_discard = 1'b0;
    resp_sel = EPCR_RESP_OK;
    if (reg_req) begin
      next_reg_done = 1'b1;
      next_reg_rdata = EPCR_ZERO64;
      if (!feature_id_present) begin
        resp_sel = EPCR_RESP_GP_FAULT;
      end else if (sel_config) begin
        if (reg_write) begin
          if (cfg_legal) begin
            next_feature_config = reg_wdata;
          end else begin
            resp_sel = EPCR_RESP_GP_FAULT;
          end
        end else begin
          next_reg_rdata = feature_config;
        end
      end else if (sel_block) begin
        if (reg_write) begin
          if (reg_wdata != EPCR_ZERO64) begin
            resp_sel = EPCR_RESP_GP_FAULT;
          end else begin
            next_control_block_address = EPCR_ZERO64;
            next_state_discard = 1'b1;
          end
        end else begin
          // Plain read, nothing flushed
          next_reg_rdata = control_block_address;
        end
      end else begin
        resp_sel = EPCR_RESP_UNMAPPED;
      end
      next_reg_resp = resp_sel;
    end else if (instr_req) begin
      // Register access wins the cycle; the core must not issue both at once
      next_instr_done = 1'b1;
      next_instr_rdata = EPCR_ZERO64;
      next_instr_resp = EPCR_RESP_OK;
      if (!instr_enabled) begin
        next_instr_resp = EPCR_RESP_UNDEF_OP;
      end else begin
        case (op_sel)
          EPCR_INSTR_LOAD: begin
            if (instr_addr == EPCR_ZERO64) begin
              // Zero only stops profiling; there is no block to validate
              next_control_block_address = EPCR_ZERO64;
            end else if (instr_block_valid) begin
              next_control_block_address = instr_addr;
            end else begin
              // Invalid block leaves the profiler disabled
              next_control_block_address = EPCR_ZERO64;
              next_instr_resp = EPCR_RESP_GP_FAULT;
            end
          end
          EPCR_INSTR_STORE: begin
            // Stored linear address as kept; segment arithmetic is left to the core
            next_instr_rdata = control_block_address;
          end
          default: begin
            next_instr_rdata = EPCR_ZERO64;
          end
        endcase
      end
    end
  end

  // Threshold interrupt only with the allow bit set
  always_comb begin
    next_irq_req = threshold_hit & profiling_on &
      feature_config[EPCR_BIT_THRESHOLD_IRQ];
  end

  // ----------------------------------------------------------------
  // Derived controls
  // ----------------------------------------------------------------
  // Taken from the next register values so that every derived output
  // changes on the same edge as the answer that caused it
  always_comb begin
    next_user_query = {next_feature_config[31:1], 1'b0};
    next_profiling_on = (next_control_block_address != EPCR_ZERO64);
    next_wraparound_mode = next_feature_config[EPCR_BIT_WRAPAROUND];
    // Bit stays in the register without a counter; only the control is gated
    next_timestamp_store = next_feature_config[EPCR_BIT_TIMESTAMP] &
      timestamp_available;
    next_core_tag = next_feature_config[EPCR_CORE_TAG_HI:EPCR_CORE_TAG_LO];
    next_block_linear_addr = next_control_block_address;
    next_irq_vector = next_feature_config[EPCR_VECTOR_HI:EPCR_VECTOR_LO];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      feature_config <= EPCR_CONFIG_RESET;
      control_block_address <= EPCR_ADDR_RESET;
      capability_word <= 32'h0000_0000;
      reg_done <= 1'b0;
      reg_resp <= 2'b00;
      reg_rdata <= 64'h0000_0000_0000_0000;
      instr_done <= 1'b0;
      instr_resp <= 2'b00;
      instr_rdata <= 64'h0000_0000_0000_0000;
      state_discard <= 1'b0;
      irq_req <= 1'b0;
    end else begin
      feature_config <= next_feature_config;
      control_block_address <= next_control_block_address;
      capability_word <= next_capability_word;
      reg_done <= next_reg_done;
      reg_resp <= next_reg_resp;
      reg_rdata <= next_reg_rdata;
      instr_done <= next_instr_done;
      instr_resp <= next_instr_resp;
      instr_rdata <= next_instr_rdata;
      state_discard <= next_state_discard;
      irq_req <= next_irq_req;
    end
  end

  // ----------------------------------------------------------------
  // Derived controls, registered so outputs come from flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      user_query <= 32'h0000_0000;
      profiling_on <= 1'b0;
      wraparound_mode <= 1'b0;
      timestamp_store <= 1'b0;
      core_tag <= 8'h00;
      block_linear_addr <= 64'h0000_0000_0000_0000;
      irq_vector <= 8'h00;
    end else begin
      user_query <= next_user_query;
      profiling_on <= next_profiling_on;
      wraparound_mode <= next_wraparound_mode;
      timestamp_store <= next_timestamp_store;
      core_tag <= next_core_tag;
      block_linear_addr <= next_block_linear_addr;
      irq_vector <= next_irq_vector;
    end
  end

  // ----------------------------------------------------------------
  // Event gate
  // ----------------------------------------------------------------
  // Gate reads registered state, so a new allow bit acts one cycle after the answer
  epcr_event_gate u_gate (
    .clk(clk),
    .reset_n(reset_n),
    .profiling_on(profiling_on),
    .allow(feature_config[EPCR_BIT_EVENT_HI:EPCR_BIT_EVENT_LO]),
    .event_raw(event_raw),
    .event_count(event_count)
  );

endmodule

// [test/epcr_top_checker.sv]
// Concurrent checks on the profiler configuration register ports
`timescale 1ns/100ps
module epcr_top_checker
  import epcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] capability_strap,
  input wire logic feature_id_present,
  input wire logic [63:0] extended_state_mask,
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_done,
  input wire logic [1:0] reg_resp,
  input wire logic instr_req,
  input wire logic instr_done,
  input wire logic [1:0] instr_resp,
  input wire logic [5:0] event_raw,
  input wire logic threshold_hit,
  input wire logic [31:0] capability_word,
  input wire logic [31:0] user_query,
  input wire logic profiling_on,
  input wire logic state_discard,
  input wire logic [63:0] block_linear_addr,
  input wire logic [5:0] event_count,
  input wire logic irq_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_answer_gate: assert property (
    reg_req && !feature_id_present |=> reg_done && reg_resp == 2'h1)
    else $error("access without feature id not refused");
  chk_cap_clean: assert property (
    $past(reset_n) |-> capability_word == (($past(capability_strap[0]) &&
    $past(feature_id_present)) ? ($past(capability_strap) & EPCR_CAP_DEFINED) : 32'h0))
    else $error("capability word wrong");
  chk_nz_fault: assert property (
    reg_req && reg_write && reg_addr == EPCR_ADDR_CONTROL_BLOCK && reg_wdata != 64'h0
    && feature_id_present |=> reg_resp == 2'h1 && $stable(block_linear_addr))
    else $error("nonzero address write not refused");
  chk_zero_stop: assert property (
    reg_req && reg_write && reg_addr == EPCR_ADDR_CONTROL_BLOCK && reg_wdata == 64'h0
    && feature_id_present |=> state_discard && !profiling_on && block_linear_addr == 64'h0)
    else $error("zero write did not stop profiling");
  chk_on_addr: assert property (profiling_on == (block_linear_addr != 64'h0))
    else $error("profiling state disagrees with address");
  chk_event_gate: assert property (
    $past(reset_n) |-> event_count == ($past(event_raw) & $past(user_query[6:1])
    & {6{$past(profiling_on)}}))
    else $error("event gating wrong");
  chk_irq_gate: assert property (
    $past(reset_n) |-> irq_req == ($past(threshold_hit) && $past(profiling_on)
    && $past(user_query[31])))
    else $error("threshold interrupt gating wrong");
  chk_instr_undef: assert property (
    instr_req && !reg_req && !(capability_strap[0] && feature_id_present
    && extended_state_mask[62]) |=> instr_done && instr_resp == 2'h2)
    else $error("instruction not refused as undefined");
endmodule

bind epcr_top epcr_top_checker u_chk (
  .clk, .reset_n, .capability_strap, .feature_id_present, .extended_state_mask,
  .reg_req, .reg_write, .reg_addr, .reg_wdata, .reg_done, .reg_resp,
  .instr_req, .instr_done, .instr_resp, .event_raw, .threshold_hit,
  .capability_word, .user_query, .profiling_on, .state_discard,
  .block_linear_addr, .event_count, .irq_req
);

// [test/tb_top.sv]
// Self-checking bench for the profiler configuration registers
`timescale 1ns/100ps
module tb_top;
  import epcr_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] capability_strap = 32'h0000_0001;
  logic feature_id_present = 1'b1;
  logic [63:0] extended_state_mask = 64'h4000_0000_0000_0000;
  logic timestamp_available = 1'b1;
  logic reg_req = 1'b0;
  logic reg_write = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [63:0] reg_wdata = 64'h0;
  logic instr_req = 1'b0;
  logic [1:0] instr_op = 2'h0;
  logic [63:0] instr_addr = 64'h0;
  logic instr_block_valid = 1'b0;
  logic [5:0] event_raw = 6'h0;
  logic threshold_hit = 1'b0;
  logic reg_done, instr_done, profiling_on, state_discard, wraparound_mode, timestamp_store;
  logic irq_req;
  logic [1:0] reg_resp, instr_resp, rs;
  logic [63:0] reg_rdata, instr_rdata, block_linear_addr, rd, d, cfg, m;
  logic [31:0] capability_word, user_query, cap;
  logic [31:0] seed = 32'h5194_6bd1;
  logic [7:0] core_tag, irq_vector;
  logic [5:0] event_count;
  logic ok;
  int mismatches = 0;
  int num_checks = 0;

  epcr_top dut (
    .clk, .reset_n, .capability_strap, .feature_id_present, .extended_state_mask,
    .timestamp_available, .reg_req, .reg_write, .reg_addr, .reg_wdata, .reg_done,
    .reg_resp, .reg_rdata, .instr_req, .instr_op, .instr_addr, .instr_block_valid,
    .instr_done, .instr_resp, .instr_rdata, .event_raw, .threshold_hit,
    .capability_word, .user_query, .profiling_on, .state_discard, .wraparound_mode,
    .timestamp_store, .core_tag, .block_linear_addr, .event_count, .irq_req, .irq_vector
  );

  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] exp_cap(input logic [31:0] s, input logic f);
    return (s[0] && f) ? (s & 32'he000_007f) : 32'h0;
  endfunction

  // Core tag and vector always writable; feature bits only when advertised
  function automatic logic [63:0] allow_mask(input logic [31:0] c);
    return 64'h0000_ffff_0000_0000 | {32'h0, c[0] ? (c & 32'he000_007e) : 32'h0};
  endfunction

  function automatic logic [5:0] exp_events(input logic [5:0] raw, input logic [63:0] c,
    input logic on);
    return on ? (raw & c[6:1]) : 6'h00;
  endfunction

  task automatic check(input logic good, input string msg);
    num_checks++;
    if (!good) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic reg_acc(input logic wr, input logic [31:0] a, input logic [63:0] wd);
    @(negedge clk);
    reg_req = 1'b1;
    reg_write = wr;
    reg_addr = a;
    reg_wdata = wd;
    @(negedge clk);
    reg_req = 1'b0;
    check(reg_done === 1'b1, "register access unanswered");
    rs = reg_resp;
    rd = reg_rdata;
  endtask

  task automatic ins(input logic [1:0] op, input logic [63:0] a, input logic v);
    @(negedge clk);
    instr_req = 1'b1;
    instr_op = op;
    instr_addr = a;
    instr_block_valid = v;
    @(negedge clk);
    instr_req = 1'b0;
    check(instr_done === 1'b1, "instruction unanswered");
    rs = instr_resp;
    rd = instr_rdata;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    cfg = 64'h0;
    reg_acc(1'b0, EPCR_ADDR_FEATURE_CONFIG, 64'h0);
    check(rs === 2'h0 && rd === 64'h0, "config reset");
    reg_acc(1'b0, EPCR_ADDR_CONTROL_BLOCK, 64'h0);
    check(rd === 64'h0 && profiling_on === 1'b0, "address reset");
    for (int i = 0; i < 24; i++) begin
      capability_strap = rnd() | {31'h0, i != 3};
      feature_id_present = (i % 6) != 5;
      timestamp_available = seed[7];
      event_raw = seed[13:8];
      threshold_hit = seed[14];
      @(negedge clk);
      @(negedge clk);
      cap = exp_cap(capability_strap, feature_id_present);
      check(capability_word === cap, "capability word");
      m = allow_mask(cap);
      d = {rnd(), rnd()};
      if (i[0]) d = d & m;
      if (i == 0) d = 64'h0000_0000_0000_0001;
      if (i == 2) d = 64'h0001_0000_0000_0000;
      reg_acc(1'b1, EPCR_ADDR_FEATURE_CONFIG, d);
      ok = feature_id_present && ((d & ~m) == 64'h0);
      check(rs === (ok ? 2'h0 : 2'h1), "config write response");
      if (ok) cfg = d;
      reg_acc(1'b0, EPCR_ADDR_FEATURE_CONFIG, 64'h0);
      check(rd === (feature_id_present ? cfg : 64'h0), "config readback");
      check({irq_vector, core_tag} === cfg[47:32], "tag and vector");
      check(wraparound_mode === cfg[29], "wraparound");
      check(user_query === {cfg[31:1], 1'b0}, "user mirror");
      check(timestamp_store === (cfg[30] & timestamp_available), "timestamp");
    end
    capability_strap = 32'hffff_ffff;
    feature_id_present = 1'b1;
    reg_acc(1'b0, 32'hc000_0107, 64'h0);
    check(rs === 2'h3 && rd === 64'h0, "unmapped read");
    reg_acc(1'b1, EPCR_ADDR_CONTROL_BLOCK, 64'h0000_0000_0000_1000);
    check(rs === 2'h1 && block_linear_addr === 64'h0, "nonzero address write");
    d = {rnd(), rnd()} | 64'h0000_0000_0000_0040;
    ins(EPCR_INSTR_LOAD, d, 1'b1);
    check(rs === 2'h0 && block_linear_addr === d, "load");
    reg_acc(1'b0, EPCR_ADDR_CONTROL_BLOCK, 64'h0);
    reg_acc(1'b0, EPCR_ADDR_CONTROL_BLOCK, 64'h0);
    check(rd === d && state_discard === 1'b0 && profiling_on === 1'b1, "address read");
    ins(EPCR_INSTR_STORE, 64'h0, 1'b0);
    check(rd === d, "store");
    cfg = 64'h0000_a53c_e000_006a;
    reg_acc(1'b1, EPCR_ADDR_FEATURE_CONFIG, cfg);
    check(rs === 2'h0 && user_query === {cfg[31:1], 1'b0}, "enable write");
    // Random events and threshold hits against the enabled set
    repeat (40) @(negedge clk) begin
      check(event_count === exp_events(event_raw, cfg, 1'b1), "event gating");
      check(irq_req === (threshold_hit & cfg[31]), "threshold interrupt");
      void'(rnd());
      event_raw = seed[5:0];
      threshold_hit = seed[9];
    end
    reg_acc(1'b1, EPCR_ADDR_CONTROL_BLOCK, 64'h0);
    check(state_discard === 1'b1 && profiling_on === 1'b0, "zero write");
    event_raw = 6'h3f;
    threshold_hit = 1'b1;
    @(negedge clk);
    check(event_count === exp_events(event_raw, cfg, 1'b0), "events when stopped");
    check(irq_req === 1'b0, "interrupt when stopped");
    ins(EPCR_INSTR_LOAD, d, 1'b0);
    check(rs === 2'h1 && block_linear_addr === 64'h0, "invalid load");
    extended_state_mask = 64'h0;
    for (int op = 0; op < 4; op++) begin
      ins(op[1:0], d, 1'b1);
      check(rs === 2'h2 && profiling_on === 1'b0, "undefined with mask clear");
    end
    extended_state_mask = 64'h4000_0000_0000_0000;
    feature_id_present = 1'b0;
    ins(EPCR_INSTR_RECORD, 64'h0, 1'b0);
    check(rs === 2'h2, "undefined when absent");
    // Second reset with a loaded configuration
    feature_id_present = 1'b1;
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    check(core_tag === 8'h00 && user_query === 32'h0 && reg_done === 1'b0, "in reset");
    reset_n = 1'b1;
    reg_acc(1'b0, EPCR_ADDR_FEATURE_CONFIG, 64'h0);
    check(rs === 2'h0 && rd === 64'h0 && irq_vector === 8'h00, "config after reset");
    finish_test();
  end
endmodule
